// ===== hdl/rf_frontend_config_regs.sv
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
// Operation
// - Read-only register shows latest conversion result.
// - Tuning A register drives converter, resets 80h.
// - Tuning B register drives converter, resets 80h.
// - Depth code maps to listed percentages, reset 7.
// - Resistance code maps to table, reset zero.
// - Regulator modulation off bit, zero means enabled.
// - Polarity bit selects external pin active level.
// - Enable bit gates modulation onto external pin.
// - Driver load modulation enable, set at reset.
// - Resistive modulation enable selects separate level.
module rf_frontend_config_regs
    import rf_frontend_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic [ADDR_WIDTH-1:0] ADDR_I,
    input wire logic [DATA_WIDTH-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [DATA_WIDTH-1:0] RDATA_O,
    input wire logic ADC_DONE_I,
    input wire logic [7:0] ADC_DATA_I,
    input wire logic MOD_ACTIVE_I,
    input wire logic LOAD_MOD_I,
    input wire logic [6:0] RESISTIVE_MODULATION_LEVEL_I,
    output logic [7:0] TUNING_LEVEL_A_O,
    output logic [7:0] TUNING_LEVEL_B_O,
    output logic [3:0] MODULATION_DEPTH_CODE_O,
    output logic [5:0] MODULATION_DEPTH_PCT_O,
    output logic [3:0] DRIVER_RES_CODE_O,
    output logic [7:0] DRIVER_RES_X10_O,
    output logic DRIVER_HIGHZ_O,
    output logic REGULATOR_MODULATION_O,
    output logic RESISTIVE_MODULATION_O,
    output logic [6:0] RESISTIVE_MODULATION_LEVEL_O,
    output logic DRIVER_MODULATION_O,
    output logic EXTERNAL_MODULATION_PIN_O
);

    typedef enum logic [5:0] {
        SEL_NONE = 6'h01,
        SEL_CONV = 6'h02,
        SEL_TUNE_A = 6'h04,
        SEL_TUNE_B = 6'h08,
        SEL_TX = 6'h10,
        SEL_MOD = 6'h20,
        SEL_STATUS = 6'h00
    } reg_sel_type;

    // The status register gets its own code outside the one-hot set so the
    // decode stays a single lookup shared by reads and writes.
    function automatic reg_sel_type decode(input logic [ADDR_WIDTH-1:0] a);
        reg_sel_type s;
        s = SEL_NONE;
        unique case (a)
            OFS_CONVERSION_RESULT: s = SEL_CONV;
            OFS_TUNING_LEVEL_A: s = SEL_TUNE_A;
            OFS_TUNING_LEVEL_B: s = SEL_TUNE_B;
            OFS_TRANSMIT_DRIVE_SETUP: s = SEL_TX;
            OFS_MODULATION_OPTIONS: s = SEL_MOD;
            OFS_BLOCK_STATUS: s = SEL_STATUS;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction : decode

    function automatic logic [7:0] pack_mod(input mod_opt_type m);
        logic [7:0] v;
        v = 8'h00;
        v[REG_OFF_POS] = m.reg_off;
        v[EXT_POL_POS] = m.ext_pol;
        v[EXT_EN_POS] = m.ext_en;
        v[DRV_EN_POS] = m.drv_en;
        v[RES_EN_POS] = m.res_en;
        return v;
    endfunction : pack_mod

    reg_sel_type wr_sel;
    reg_sel_type rd_sel;
    logic wr_hit;

    fe_cfg_type cfg_r;
    fe_cfg_type cfg_nxt;
    logic [7:0] tune_a_r;
    logic [7:0] tune_a_nxt;
    logic [7:0] tune_b_r;
    logic [7:0] tune_b_nxt;
    tx_drive_type tx_r;
    tx_drive_type tx_nxt;
    mod_opt_type mod_r;
    mod_opt_type mod_nxt;
    logic [7:0] conv_r;
    logic [7:0] conv_nxt;
    logic fresh_r;
    logic fresh_nxt;
    logic refused_r;
    logic refused_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    fe_drive_type drive;

    assign wr_sel = decode(ADDR_I);
    assign rd_sel = decode(ADDR_I);
    assign wr_hit = WR_I && (wr_sel != SEL_NONE) && (wr_sel != SEL_CONV);

    // Tuning level A feeds the first tuning converter as stored.
    always_comb
    begin
        tune_a_nxt = tune_a_r;
        if (WR_I && (wr_sel == SEL_TUNE_A))
        begin
            tune_a_nxt = WDATA_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            tune_a_r <= RST_TUNING_LEVEL;
        end
        else
        begin
            tune_a_r <= tune_a_nxt;
        end
    end

    // Tuning level B feeds the second tuning converter as stored.
    always_comb
    begin
        tune_b_nxt = tune_b_r;
        if (WR_I && (wr_sel == SEL_TUNE_B))
        begin
            tune_b_nxt = WDATA_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            tune_b_r <= RST_TUNING_LEVEL;
        end
        else
        begin
            tune_b_r <= tune_b_nxt;
        end
    end

    // Transmit drive setup: depth code above, resistance code below.
    always_comb
    begin
        tx_nxt = tx_r;
        if (WR_I && (wr_sel == SEL_TX))
        begin
            tx_nxt.depth = WDATA_I[DEPTH_POS +: 4];
            tx_nxt.res = WDATA_I[RES_POS +: 4];
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            tx_r.depth <= RST_DEPTH_CODE;
            tx_r.res <= RST_RES_CODE;
        end
        else
        begin
            tx_r <= tx_nxt;
        end
    end

    // Only the five defined option bits are stored, so the low three bits
    // of a write are dropped and can only read back as zero.
    always_comb
    begin
        mod_nxt = mod_r;
        if (WR_I && (wr_sel == SEL_MOD))
        begin
            mod_nxt.reg_off = WDATA_I[REG_OFF_POS];
            mod_nxt.ext_pol = WDATA_I[EXT_POL_POS];
            mod_nxt.ext_en = WDATA_I[EXT_EN_POS];
            mod_nxt.drv_en = WDATA_I[DRV_EN_POS];
            mod_nxt.res_en = WDATA_I[RES_EN_POS];
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            mod_r.reg_off <= RST_REG_OFF;
            mod_r.ext_pol <= RST_EXT_POL;
            mod_r.ext_en <= RST_EXT_EN;
            mod_r.drv_en <= RST_DRV_EN;
            mod_r.res_en <= RST_RES_EN;
        end
        else
        begin
            mod_r <= mod_nxt;
        end
    end

    // The drive stage decodes the next configuration, so a write reaches
    // the front end at the same edge that stores it.
    assign cfg_nxt = '{tuning_a: tune_a_nxt, tuning_b: tune_b_nxt,
                       tx: tx_nxt, mod: mod_nxt};
    assign cfg_r = '{tuning_a: tune_a_r, tuning_b: tune_b_r,
                     tx: tx_r, mod: mod_r};

    // Conversion capture.
    always_comb
    begin
        conv_nxt = conv_r;
        if (ADC_DONE_I)
        begin
            conv_nxt = ADC_DATA_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            conv_r <= RST_CONVERSION_RESULT;
        end
        else
        begin
            conv_r <= conv_nxt;
        end
    end

    // Fresh-result flag. A completed conversion wins over the clear made
    // by reading the result in the same cycle, so no result goes unseen.
    always_comb
    begin
        fresh_nxt = fresh_r;
        if (RD_I && (rd_sel == SEL_CONV))
        begin
            fresh_nxt = 1'b0;
        end
        if (ADC_DONE_I)
        begin
            fresh_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            fresh_r <= 1'b0;
        end
        else
        begin
            fresh_r <= fresh_nxt;
        end
    end

    // Refused-write flag, cleared by writing one to its status bit. Writes
    // to the result or to holes change nothing but are flagged, and a new
    // refusal wins over a clear in the same cycle.
    always_comb
    begin
        refused_nxt = refused_r;
        if (WR_I && (wr_sel == SEL_STATUS) && WDATA_I[REFUSED_POS])
        begin
            refused_nxt = 1'b0;
        end
        if (WR_I && !wr_hit && (wr_sel != SEL_STATUS))
        begin
            refused_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            refused_r <= 1'b0;
        end
        else
        begin
            refused_r <= refused_nxt;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (RD_I)
        begin
            unique case (rd_sel)
                SEL_CONV: rdata_nxt = conv_r;
                SEL_TUNE_A: rdata_nxt = cfg_r.tuning_a;
                SEL_TUNE_B: rdata_nxt = cfg_r.tuning_b;
                SEL_TX: rdata_nxt = {cfg_r.tx.depth, cfg_r.tx.res};
                SEL_MOD: rdata_nxt = pack_mod(cfg_r.mod);
                SEL_STATUS:
                begin
                    rdata_nxt[FRESH_POS] = fresh_r;
                    rdata_nxt[REFUSED_POS] = refused_r;
                end
                SEL_NONE: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // The target-mode resistances live outside this bank; driver load
    // modulation assumes software set them before entering target mode.
    rf_frontend_drive u_drive
    (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .cfg_nxt_i(cfg_nxt),
        .mod_active_i(MOD_ACTIVE_I),
        .load_mod_i(LOAD_MOD_I),
        .res_level_i(RESISTIVE_MODULATION_LEVEL_I),
        .drive_o(drive)
    );

    assign RDATA_O = rdata_r;
    assign TUNING_LEVEL_A_O = cfg_r.tuning_a;
    assign TUNING_LEVEL_B_O = cfg_r.tuning_b;
    assign MODULATION_DEPTH_CODE_O = cfg_r.tx.depth;
    assign DRIVER_RES_CODE_O = cfg_r.tx.res;
    assign MODULATION_DEPTH_PCT_O = drive.depth_pct;
    assign DRIVER_RES_X10_O = drive.res_x10;
    assign DRIVER_HIGHZ_O = drive.highz;
    assign REGULATOR_MODULATION_O = drive.regulator_am;
    assign RESISTIVE_MODULATION_O = drive.resistive_am;
    assign RESISTIVE_MODULATION_LEVEL_O = drive.resistive_level;
    assign DRIVER_MODULATION_O = drive.driver_load_mod;
    assign EXTERNAL_MODULATION_PIN_O = drive.ext_pin;

endmodule : rf_frontend_config_regs

// ===== hdl/rf_frontend_pkg.sv
package rf_frontend_pkg;

    localparam int ADDR_WIDTH = 7;
    localparam int DATA_WIDTH = 8;

    // Bit 6 of the address picks the second register space.
    localparam int SPACE_B_BIT = 6;

    localparam logic [6:0] OFS_CONVERSION_RESULT = 7'h25;
    localparam logic [6:0] OFS_TUNING_LEVEL_A = 7'h26;
    localparam logic [6:0] OFS_TUNING_LEVEL_B = 7'h27;
    localparam logic [6:0] OFS_TRANSMIT_DRIVE_SETUP = 7'h28;
    localparam logic [6:0] OFS_MODULATION_OPTIONS = 7'h68;
    localparam logic [6:0] OFS_BLOCK_STATUS = 7'h3f;

    localparam logic [7:0] RST_CONVERSION_RESULT = 8'h00;
    localparam logic [7:0] RST_TUNING_LEVEL = 8'h80;
    localparam logic [3:0] RST_DEPTH_CODE = 4'h7;
    localparam logic [3:0] RST_RES_CODE = 4'h0;
    localparam logic RST_REG_OFF = 1'b0;
    localparam logic RST_EXT_POL = 1'b0;
    localparam logic RST_EXT_EN = 1'b0;
    localparam logic RST_DRV_EN = 1'b1;
    localparam logic RST_RES_EN = 1'b0;

    localparam int DEPTH_POS = 4;
    localparam int RES_POS = 0;
    localparam int REG_OFF_POS = 7;
    localparam int EXT_POL_POS = 6;
    localparam int EXT_EN_POS = 5;
    localparam int DRV_EN_POS = 4;
    localparam int RES_EN_POS = 3;
    localparam int FRESH_POS = 0;
    localparam int REFUSED_POS = 1;

    localparam logic [3:0] RES_CODE_HIGHZ = 4'hf;
    localparam logic [3:0] DEPTH_LINEAR_LAST = 4'ha;
    localparam logic [5:0] DEPTH_BASE_PCT = 6'h05;

    typedef struct packed {
        logic [3:0] depth;
        logic [3:0] res;
    } tx_drive_type;

    typedef struct packed {
        logic reg_off;
        logic ext_pol;
        logic ext_en;
        logic drv_en;
        logic res_en;
    } mod_opt_type;

    typedef struct packed {
        logic [7:0] tuning_a;
        logic [7:0] tuning_b;
        tx_drive_type tx;
        mod_opt_type mod;
    } fe_cfg_type;

    typedef struct packed {
        logic [5:0] depth_pct;
        logic [7:0] res_x10;
        logic highz;
        logic regulator_am;
        logic resistive_am;
        logic [6:0] resistive_level;
        logic driver_load_mod;
        logic ext_pin;
    } fe_drive_type;

endpackage : rf_frontend_pkg

// ===== hdl/rf_frontend_drive.sv
`timescale 1ns/10ps
module rf_frontend_drive
    import rf_frontend_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire fe_cfg_type cfg_nxt_i,
    input wire logic mod_active_i,
    input wire logic load_mod_i,
    input wire logic [6:0] res_level_i,
    output fe_drive_type drive_o
);

    function automatic logic [5:0] depth_pct(input logic [3:0] code);
        logic [5:0] pct;
        pct = 6'h00;
        if (code <= DEPTH_LINEAR_LAST)
        begin
            pct = DEPTH_BASE_PCT + {2'b00, code};
        end
        else
        begin
            unique case (code)
                4'hb: pct = 6'h11;
                4'hc: pct = 6'h13;
                4'hd: pct = 6'h16;
                4'he: pct = 6'h1a;
                default: pct = 6'h28;
            endcase
        end
        return pct;
    endfunction : depth_pct

    // Resistance in tenths of the unit driver resistance; zero when open.
    function automatic logic [7:0] res_x10(input logic [3:0] code);
        logic [7:0] r;
        r = 8'h00;
        unique case (code)
            4'h0: r = 8'h0a;
            4'h1: r = 8'h14;
            4'h2: r = 8'h29;
            4'h3, 4'h4: r = 8'h53;
            4'hf: r = 8'h00;
            default: r = 8'hab;
        endcase
        return r;
    endfunction : res_x10

    // Reset shows the decoded reset codes, so the converted outputs agree
    // with the stored codes from the first cycle after reset on; the
    // modulation gates rest low because their inputs are not yet known.
    localparam fe_drive_type DRIVE_RST = fe_drive_type'({
        depth_pct(RST_DEPTH_CODE),
        res_x10(RST_RES_CODE),
        (RST_RES_CODE == RES_CODE_HIGHZ),
        11'h000});

    fe_drive_type drive_r;
    fe_drive_type drive_nxt;

    // Computed from the next configuration so that a write shows on the
    // outputs right after the edge that stores it, not one edge later.
    always_comb
    begin
        drive_nxt = '0;
        drive_nxt.depth_pct = depth_pct(cfg_nxt_i.tx.depth);
        drive_nxt.res_x10 = res_x10(cfg_nxt_i.tx.res);
        drive_nxt.highz = (cfg_nxt_i.tx.res == RES_CODE_HIGHZ);
        drive_nxt.regulator_am = ~cfg_nxt_i.mod.reg_off
                                 & mod_active_i;
        drive_nxt.resistive_am = cfg_nxt_i.mod.res_en
                                 & mod_active_i;
        drive_nxt.resistive_level = cfg_nxt_i.mod.res_en ? res_level_i
                                                         : 7'h00;
        drive_nxt.driver_load_mod = cfg_nxt_i.mod.drv_en
                                    & load_mod_i;
        // Disabled pin rests at its inactive level for the chosen polarity.
        drive_nxt.ext_pin = (cfg_nxt_i.mod.ext_en & load_mod_i)
                            ^ cfg_nxt_i.mod.ext_pol;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            drive_r <= DRIVE_RST;
        end
        else
        begin
            drive_r <= drive_nxt;
        end
    end

    assign drive_o = drive_r;

endmodule : rf_frontend_drive

// ===== tb/rf_frontend_config_regs_sva.sv
`timescale 1ns/10ps
module rf_frontend_config_regs_sva
    import rf_frontend_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic [ADDR_WIDTH-1:0] ADDR_I,
    input wire logic [DATA_WIDTH-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [DATA_WIDTH-1:0] RDATA_O,
    input wire logic ADC_DONE_I,
    input wire logic [7:0] ADC_DATA_I,
    input wire logic MOD_ACTIVE_I,
    input wire logic LOAD_MOD_I,
    input wire logic [6:0] RESISTIVE_MODULATION_LEVEL_I,
    input wire logic [7:0] TUNING_LEVEL_A_O,
    input wire logic [3:0] MODULATION_DEPTH_CODE_O,
    input wire logic [5:0] MODULATION_DEPTH_PCT_O,
    input wire logic [3:0] DRIVER_RES_CODE_O,
    input wire logic [7:0] DRIVER_RES_X10_O,
    input wire logic DRIVER_HIGHZ_O,
    input wire logic REGULATOR_MODULATION_O,
    input wire logic RESISTIVE_MODULATION_O,
    input wire logic [6:0] RESISTIVE_MODULATION_LEVEL_O,
    input wire logic DRIVER_MODULATION_O,
    input wire logic EXTERNAL_MODULATION_PIN_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);
    wire wr_opt = WR_I && ADDR_I == OFS_MODULATION_OPTIONS;
    wire rd_opt = RD_I && ADDR_I == OFS_MODULATION_OPTIONS;
    wire rd_adc = RD_I && ADDR_I == OFS_CONVERSION_RESULT;
    a_rdata_idle_zero:
    assert property (!RD_I |=> RDATA_O == 8'h00)
        else $error("read data not zero outside a read");
    a_adc_read_back:
    assert property (ADC_DONE_I ##1 !ADC_DONE_I ##1 (rd_adc && !ADC_DONE_I)
        |=> RDATA_O == $past(ADC_DATA_I, 3))
        else $error("conversion result read back wrong");
    a_tuning_write_lands:
    assert property (WR_I && ADDR_I == OFS_TUNING_LEVEL_A
        |=> TUNING_LEVEL_A_O == $past(WDATA_I))
        else $error("tuning level not taken from write");
    a_depth_linear_map:
    assert property (MODULATION_DEPTH_CODE_O <= 4'ha
        |-> MODULATION_DEPTH_PCT_O == {2'h0, MODULATION_DEPTH_CODE_O} + 6'h05)
        else $error("depth percent wrong in linear range");
    a_res_mid_codes:
    assert property (DRIVER_RES_CODE_O inside {4'h3, 4'h4}
        |-> DRIVER_RES_X10_O == 8'h53)
        else $error("driver resistance wrong for codes three and four");
    a_highz_code_only:
    assert property (DRIVER_HIGHZ_O == (DRIVER_RES_CODE_O == 4'hf))
        else $error("high impedance flag disagrees with code");
    a_regulator_sense:
    assert property (wr_opt |=> REGULATOR_MODULATION_O ==
        (!$past(WDATA_I[7]) && $past(MOD_ACTIVE_I)))
        else $error("regulator modulation sense wrong");
    a_ext_pin_level:
    assert property (wr_opt |=> EXTERNAL_MODULATION_PIN_O ==
        (($past(WDATA_I[5]) && $past(LOAD_MOD_I)) ^ $past(WDATA_I[6])))
        else $error("external modulation pin level wrong");
    a_driver_mod_gate:
    assert property (wr_opt |=> DRIVER_MODULATION_O ==
        ($past(WDATA_I[4]) && $past(LOAD_MOD_I)))
        else $error("driver load modulation gate wrong");
    a_resistive_gate:
    assert property (wr_opt |=> RESISTIVE_MODULATION_O ==
        ($past(WDATA_I[3]) && $past(MOD_ACTIVE_I)) &&
        RESISTIVE_MODULATION_LEVEL_O == ($past(WDATA_I[3]) ?
        $past(RESISTIVE_MODULATION_LEVEL_I) : 7'h00))
        else $error("resistive modulation gate wrong");
    a_reserved_read_zero:
    assert property (rd_opt |=> RDATA_O[2:0] == 3'h0)
        else $error("reserved option bits not zero");
    c_tuning_write: cover property (WR_I && ADDR_I == OFS_TUNING_LEVEL_A);
    c_adc_read: cover property (rd_adc ##1 RDATA_O != 8'h00);
    c_pin_inverse: cover property (wr_opt && WDATA_I[6]);
endmodule : rf_frontend_config_regs_sva

bind rf_frontend_config_regs rf_frontend_config_regs_sva u_sva (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .ADC_DONE_I(ADC_DONE_I), .ADC_DATA_I(ADC_DATA_I),
    .MOD_ACTIVE_I(MOD_ACTIVE_I), .LOAD_MOD_I(LOAD_MOD_I),
    .RESISTIVE_MODULATION_LEVEL_I(RESISTIVE_MODULATION_LEVEL_I),
    .TUNING_LEVEL_A_O(TUNING_LEVEL_A_O),
    .MODULATION_DEPTH_CODE_O(MODULATION_DEPTH_CODE_O),
    .MODULATION_DEPTH_PCT_O(MODULATION_DEPTH_PCT_O),
    .DRIVER_RES_CODE_O(DRIVER_RES_CODE_O),
    .DRIVER_RES_X10_O(DRIVER_RES_X10_O), .DRIVER_HIGHZ_O(DRIVER_HIGHZ_O),
    .REGULATOR_MODULATION_O(REGULATOR_MODULATION_O),
    .RESISTIVE_MODULATION_O(RESISTIVE_MODULATION_O),
    .RESISTIVE_MODULATION_LEVEL_O(RESISTIVE_MODULATION_LEVEL_O),
    .DRIVER_MODULATION_O(DRIVER_MODULATION_O),
    .EXTERNAL_MODULATION_PIN_O(EXTERNAL_MODULATION_PIN_O)
);

// ===== tb/rf_frontend_config_regs_tb.sv
`timescale 1ns/10ps
module rf_frontend_config_regs_tb
    import rf_frontend_pkg::*;
;
    logic CLK_I = 1'b0;
    logic RESETN_I = 1'b0;
    logic [6:0] ADDR_I = 7'h00;
    logic [7:0] WDATA_I = 8'h00;
    logic WR_I = 1'b0;
    logic RD_I = 1'b0;
    logic ADC_DONE_I = 1'b0;
    logic [7:0] ADC_DATA_I = 8'h00;
    logic MOD_ACTIVE_I = 1'b0;
    logic LOAD_MOD_I = 1'b0;
    logic [6:0] RES_LVL_I = 7'h2b;
    logic [7:0] RDATA_O, TUN_A, TUN_B, RES_X10;
    logic [3:0] DEPTH, RES_CODE;
    logic [5:0] PCT;
    logic HIGHZ, REG_MOD, RES_MOD, DRV_MOD, PIN;
    logic [6:0] RES_LVL_O;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [5:0] pct_tab [16] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a,
        6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h11, 6'h13, 6'h16, 6'h1a, 6'h28};
    logic [7:0] res_tab [16] = '{8'h0a, 8'h14, 8'h29, 8'h53, 8'h53, 8'hab,
        8'hab, 8'hab, 8'hab, 8'hab, 8'hab, 8'hab, 8'hab, 8'hab, 8'hab, 8'h00};
    logic [7:0] opt_tab [4] = '{8'h00, 8'hff, 8'h60, 8'h98};

    rf_frontend_config_regs u_rf_frontend_config_regs (
        .CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
        .ADC_DONE_I(ADC_DONE_I), .ADC_DATA_I(ADC_DATA_I),
        .MOD_ACTIVE_I(MOD_ACTIVE_I), .LOAD_MOD_I(LOAD_MOD_I),
        .RESISTIVE_MODULATION_LEVEL_I(RES_LVL_I),
        .TUNING_LEVEL_A_O(TUN_A), .TUNING_LEVEL_B_O(TUN_B),
        .MODULATION_DEPTH_CODE_O(DEPTH), .MODULATION_DEPTH_PCT_O(PCT),
        .DRIVER_RES_CODE_O(RES_CODE), .DRIVER_RES_X10_O(RES_X10),
        .DRIVER_HIGHZ_O(HIGHZ), .REGULATOR_MODULATION_O(REG_MOD),
        .RESISTIVE_MODULATION_O(RES_MOD),
        .RESISTIVE_MODULATION_LEVEL_O(RES_LVL_O),
        .DRIVER_MODULATION_O(DRV_MOD), .EXTERNAL_MODULATION_PIN_O(PIN)
    );

    always #10 CLK_I = ~CLK_I;

    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Each bus task drives right after an edge; the write task leaves its strobe
    // for the next task to change, so back-to-back writes never double-assign,
    // and the read task drops its own read strobe one edge later.
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        RD_I <= 1'b0;
    endtask : wr

    task rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge CLK_I);
        ADDR_I <= a;
        WR_I <= 1'b0;
        RD_I <= 1'b1;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        @(negedge CLK_I);
        d = RDATA_O;
    endtask : rd

    task idle;
        @(posedge CLK_I);
        WR_I <= 1'b0;
        RD_I <= 1'b0;
        @(negedge CLK_I);
    endtask : idle

    task t_reset;
        logic [7:0] d;
        rd(OFS_TUNING_LEVEL_A, d);
        chk(d, 8'h80);
        rd(OFS_TUNING_LEVEL_B, d);
        chk(d, 8'h80);
        rd(OFS_TRANSMIT_DRIVE_SETUP, d);
        chk(d, 8'h70);
        rd(OFS_MODULATION_OPTIONS, d);
        chk(d, 8'h10);
        chk(TUN_B, 8'h80);
        $display("t_reset finished");
    endtask : t_reset

    task t_tuning;
        logic [7:0] d;
        wr(OFS_TUNING_LEVEL_A, 8'h55);
        wr(OFS_TUNING_LEVEL_B, 8'haa);
        idle();
        chk(TUN_A, 8'h55);
        chk(TUN_B, 8'haa);
        rd(OFS_TUNING_LEVEL_A, d);
        chk(d, 8'h55);
        rd(OFS_TUNING_LEVEL_B, d);
        chk(d, 8'haa);
        $display("t_tuning finished");
    endtask : t_tuning

    task t_adc;
        logic [7:0] d;
        @(posedge CLK_I);
        ADC_DATA_I <= 8'h3c;
        ADC_DONE_I <= 1'b1;
        @(posedge CLK_I);
        ADC_DONE_I <= 1'b0;
        ADC_DATA_I <= 8'hc3;
        rd(OFS_CONVERSION_RESULT, d);
        chk(d, 8'h3c);
        wr(OFS_CONVERSION_RESULT, 8'h5a);
        rd(OFS_CONVERSION_RESULT, d);
        chk(d, 8'h3c);
        rd(7'h10, d);
        chk(d, 8'h00);
        rd(OFS_BLOCK_STATUS, d);
        chk(d, 8'h02);
        wr(OFS_BLOCK_STATUS, 8'h02);
        rd(OFS_BLOCK_STATUS, d);
        chk(d, 8'h00);
        $display("t_adc finished");
    endtask : t_adc

    task t_drive_table;
        for (int c = 0; c < 16; c++)
        begin
            wr(OFS_TRANSMIT_DRIVE_SETUP, {c[3:0], c[3:0]});
            idle();
            chk({2'h0, PCT}, {2'h0, pct_tab[c]});
            chk(RES_X10, res_tab[c]);
            chk({7'h00, HIGHZ}, {7'h00, c == 15});
        end
        $display("t_drive_table finished");
    endtask : t_drive_table

    task t_options;
        logic [7:0] v;
        logic [7:0] d;
        logic l;
        for (int i = 0; i < 8; i++)
        begin
            v = opt_tab[i % 4];
            l = i[2];
            @(posedge CLK_I);
            // Target-mode resistances live outside this block and are taken
            // as programmed before load modulation is driven here.
            LOAD_MOD_I <= l;
            MOD_ACTIVE_I <= l;
            wr(OFS_MODULATION_OPTIONS, v);
            idle();
            chk({7'h00, REG_MOD}, {7'h00, !v[7] & l});
            chk({7'h00, RES_MOD}, {7'h00, v[3] & l});
            chk({7'h00, DRV_MOD}, {7'h00, v[4] & l});
            chk({7'h00, PIN}, {7'h00, (v[5] & l) ^ v[6]});
            chk({1'b0, RES_LVL_O}, v[3] ? 8'h2b : 8'h00);
            rd(OFS_MODULATION_OPTIONS, d);
            chk(d, v & 8'hf8);
        end
        $display("t_options finished");
    endtask : t_options

    always @(posedge CLK_I)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (8) @(posedge CLK_I);
        RESETN_I <= 1'b1;
        t_reset();
        t_tuning();
        t_adc();
        t_drive_table();
        t_options();
        wrap_up();
    end
endmodule : rf_frontend_config_regs_tb
